// [hdl/pld_consts.vh]
// register map, field positions and reset values of the pll divider block
`ifndef PLD_CONSTS_VH
`define PLD_CONSTS_VH

// register indices; byte address is four times the index
`define PLD_IDX_COUNTER_RESET 8'h09
`define PLD_IDX_PRESCALER_CTRL 8'h0a
`define PLD_IDX_REF_DIV_HIGH 8'h0b
`define PLD_IDX_REF_DIV_LOW 8'h0c
`define PLD_IDX_DIST_SELECT 8'h45
`define PLD_IDX_SWALLOW_COUNT 8'h04
`define PLD_IDX_MAIN_DIV_HIGH 8'h05
`define PLD_IDX_MAIN_DIV_LOW 8'h06
`define PLD_IDX_STATUS 8'h0f
`define PLD_IDX_REF_PULSE_COUNT 8'h10
`define PLD_IDX_FB_PULSE_COUNT 8'h11

// field positions
`define PLD_BIT_SHARED_RESET 0
`define PLD_BIT_AB_RESET 1
`define PLD_MODE_LSB 2
`define PLD_MODE_MSB 4
`define PLD_BIT_MAIN_BYPASS 6
`define PLD_BIT_DIST_SELECT 0

// widths
`define PLD_REF_W 14
`define PLD_SWALLOW_W 6
`define PLD_MAIN_W 13

// reset values and the lowest main count the status accepts
`define PLD_RST_COUNTER_RESET 2'h0
`define PLD_RST_PRESCALER_MODE 3'h0
`define PLD_RST_MAIN_BYPASS 1'h0
`define PLD_RST_REF_DIV 14'h0000
`define PLD_RST_SWALLOW 6'h00
`define PLD_RST_MAIN_DIV 13'h0000
`define PLD_RST_DIST_SELECT 1'h1
`define PLD_MAIN_MIN 13'h0003

// prescaler mode codes
`define PLD_PS_FD1 3'h0
`define PLD_PS_FD2 3'h1
`define PLD_PS_DM2 3'h2
`define PLD_PS_DM4 3'h3
`define PLD_PS_DM8 3'h4
`define PLD_PS_DM16 3'h5
`define PLD_PS_DM32 3'h6
`define PLD_PS_FD3 3'h7

`endif

// [hdl/pld_divider.v]
// programmable divide-by-n pulse counter
`timescale 1ns/1ps
module pld_divider #(
    parameter W = 14
) (
    clk,
    rst_n,
    clr,
    tick,
    div_val,
    pulse
);
    input wire clk;
    input wire rst_n;
    input wire clr;
    input wire tick;
    input wire [W-1:0] div_val;
    output reg pulse;

    reg [W-1:0] cnt_reg;
    wire [W-1:0] last_w;

    // zero behaves like one
    assign last_w = (div_val == {W{1'b0}}) ? {W{1'b0}} : div_val - {{(W-1){1'b0}}, 1'b1};

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= {W{1'b0}};
            pulse <= 1'b0;
        end else if (clr) begin
            cnt_reg <= {W{1'b0}};
            pulse <= 1'b0;
        end else begin
            pulse <= 1'b0;
            if (tick) begin
                if (cnt_reg >= last_w) begin
                    cnt_reg <= {W{1'b0}};
                    pulse <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

// [hdl/pld_prescaler.v]
// multi-mode prescaler: fixed 1/2/3 or dual modulus p/p+1
`timescale 1ns/1ps
`include "pld_consts.vh"
module pld_prescaler (
    clk,
    rst_n,
    clr,
    tick,
    mode,
    mod_hi,
    pulse
);
    input wire clk;
    input wire rst_n;
    input wire clr;
    input wire tick;
    input wire [2:0] mode;
    input wire mod_hi;
    output reg pulse;

    reg [5:0] cnt_reg;
    reg [5:0] last_c;

    always @* begin
        case (mode)
            `PLD_PS_FD1: last_c = 6'h00;
            `PLD_PS_FD2: last_c = 6'h01;
            `PLD_PS_FD3: last_c = 6'h02;
            `PLD_PS_DM2: last_c = 6'h01 + {5'h00, mod_hi};
            `PLD_PS_DM4: last_c = 6'h03 + {5'h00, mod_hi};
            `PLD_PS_DM8: last_c = 6'h07 + {5'h00, mod_hi};
            `PLD_PS_DM16: last_c = 6'h0f + {5'h00, mod_hi};
            `PLD_PS_DM32: last_c = 6'h1f + {5'h00, mod_hi};
            default: last_c = 6'h00;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 6'h00;
            pulse <= 1'b0;
        end else if (clr) begin
            cnt_reg <= 6'h00;
            pulse <= 1'b0;
        end else begin
            pulse <= 1'b0;
            if (tick) begin
                if (cnt_reg >= last_c) begin
                    cnt_reg <= 6'h00;
                    pulse <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 6'h01;
                end
            end
        end
    end
endmodule

// [hdl/pld_top.v]
// pll reference and feedback dividers with ahb-lite register slave
//
// Notes on behaviour
// - select bit zero routes oscillator to distribution
// - auxiliary input feeds distribution after reset
// - only oscillator input drives feedback divider
// - reference divider is 14-bit, hclk clocked, counts reference edges
// - reference divides 1..16383, zero means one
// - reference value from high and low fields
// - reference divider output goes to detector
// - prescaler 3-bit mode, 6-bit swallow, 13-bit main
// - mode codes select fixed or dual ratios
// - fixed modes ignore swallow; main may bypass
// - bypass bit one makes main divide one
// - main count resets zero, software overwrites
// - dedicated bit resets prescaler, swallow and main only
// - shared bit resets reference, swallow, main
// - dual mode divides by p*main plus swallow
// - fixed mode divides by ratio times main
`timescale 1ns/1ps
`include "pld_consts.vh"
module pld_top (
    hclk,
    hresetn,
    hsel,
    haddr,
    htrans,
    hwrite,
    hsize,
    hwdata,
    hready,
    hreadyout,
    hresp,
    hrdata,
    reference_clock_input,
    auxiliary_clock_input,
    oscillator_feedback_input,
    distribution_clock,
    pfd_reference_pulse,
    pfd_feedback_pulse
);
    input wire hclk;
    input wire hresetn;
    input wire hsel;
    input wire [31:0] haddr;
    input wire [1:0] htrans;
    input wire hwrite;
    input wire [2:0] hsize;
    input wire [31:0] hwdata;
    input wire hready;
    output wire hreadyout;
    output wire hresp;
    output reg [31:0] hrdata;

    input wire reference_clock_input;
    input wire auxiliary_clock_input;
    input wire oscillator_feedback_input;

    output wire distribution_clock;
    output wire pfd_reference_pulse;
    output reg pfd_feedback_pulse;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // fixed modes are 000, 001 and 111; the rest are dual modulus
    function is_dual;
        input [2:0] mode;
        begin
            is_dual = (mode != `PLD_PS_FD1) && (mode != `PLD_PS_FD2) && (mode != `PLD_PS_FD3);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // control registers

    // reset levels are held by software, never self-cleared
    reg shared_reset_reg;
    reg ab_reset_reg;

    // divide settings as written
    reg [2:0] ps_mode_reg;
    reg main_bypass_reg;
    reg [`PLD_REF_W-1:0] ref_div_reg;
    reg [`PLD_SWALLOW_W-1:0] swallow_reg;
    reg [`PLD_MAIN_W-1:0] main_div_reg;

    reg dist_select_reg;

    // read-only tallies that wrap at 256
    reg [7:0] ref_pulse_cnt_reg;
    reg [7:0] fb_pulse_cnt_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // ahb-lite slave: writes take no wait, reads take one wait state

    // data-phase copies of the address phase
    reg dp_valid_reg;
    reg dp_write_reg;
    reg dp_ok_reg;
    reg [7:0] dp_idx_reg;

    reg rd_wait_reg;
    reg [31:0] rd_word;

    wire take;
    wire wr_commit;

    // seq is taken like nonseq; idle and busy start nothing
    assign take = hsel & hready & htrans[1];
    assign hreadyout = ~rd_wait_reg;
    assign hresp = 1'b0;
    assign wr_commit = dp_valid_reg & dp_write_reg & dp_ok_reg;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_ok_reg <= 1'b0;
            dp_idx_reg <= 8'h00;
            rd_wait_reg <= 1'b0;
        end else begin
            if (hreadyout) begin
                dp_valid_reg <= take;
                if (take) begin
                    dp_write_reg <= hwrite;
                    dp_idx_reg <= haddr[9:2];
                    // anything outside the word-aligned window reads zero, writes are dropped
                    dp_ok_reg <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
                end
            end
            // a read stalls its data phase once, a write never
            rd_wait_reg <= hreadyout & take & ~hwrite;
        end
    end

    // hrdata holds between reads, so a late sample is safe
    // the wait state lets a read see a write committed just before it
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (rd_wait_reg) begin
            hrdata <= dp_ok_reg ? rd_word : 32'h00000000;
        end
    end

    always @* begin
        rd_word = 32'h00000000;
        case (dp_idx_reg)
            `PLD_IDX_COUNTER_RESET: begin
                rd_word[`PLD_BIT_SHARED_RESET] = shared_reset_reg;
                rd_word[`PLD_BIT_AB_RESET] = ab_reset_reg;
            end
            `PLD_IDX_PRESCALER_CTRL: begin
                rd_word[`PLD_MODE_MSB:`PLD_MODE_LSB] = ps_mode_reg;
                rd_word[`PLD_BIT_MAIN_BYPASS] = main_bypass_reg;
            end
            `PLD_IDX_REF_DIV_HIGH: rd_word[5:0] = ref_div_reg[13:8];
            `PLD_IDX_REF_DIV_LOW: rd_word[7:0] = ref_div_reg[7:0];
            `PLD_IDX_DIST_SELECT: rd_word[`PLD_BIT_DIST_SELECT] = dist_select_reg;
            `PLD_IDX_SWALLOW_COUNT: rd_word[5:0] = swallow_reg;
            `PLD_IDX_MAIN_DIV_HIGH: rd_word[4:0] = main_div_reg[12:8];
            `PLD_IDX_MAIN_DIV_LOW: rd_word[7:0] = main_div_reg[7:0];
            // status is derived live and has no write path
            `PLD_IDX_STATUS: begin
                rd_word[0] = is_dual(ps_mode_reg);
                // flags a main count the divider cannot honour
                rd_word[1] = ~main_bypass_reg & (main_div_reg < `PLD_MAIN_MIN);
                // bypass outside fixed mode is a software fault
                rd_word[2] = main_bypass_reg & is_dual(ps_mode_reg);
                rd_word[3] = dist_select_reg;
            end
            `PLD_IDX_REF_PULSE_COUNT: rd_word[7:0] = ref_pulse_cnt_reg;
            `PLD_IDX_FB_PULSE_COUNT: rd_word[7:0] = fb_pulse_cnt_reg;
            default: rd_word = 32'h00000000;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shared_reset_reg <= 1'b0;
            ab_reset_reg <= 1'b0;
            ps_mode_reg <= `PLD_RST_PRESCALER_MODE;
            main_bypass_reg <= `PLD_RST_MAIN_BYPASS;
            ref_div_reg <= `PLD_RST_REF_DIV;
            swallow_reg <= `PLD_RST_SWALLOW;
            main_div_reg <= `PLD_RST_MAIN_DIV;
            dist_select_reg <= `PLD_RST_DIST_SELECT;
        // hwdata stands in the data phase and is taken at its end edge
        end else if (wr_commit) begin
            case (dp_idx_reg)
                `PLD_IDX_COUNTER_RESET: begin
                    shared_reset_reg <= hwdata[`PLD_BIT_SHARED_RESET];
                    ab_reset_reg <= hwdata[`PLD_BIT_AB_RESET];
                end
                `PLD_IDX_PRESCALER_CTRL: begin
                    ps_mode_reg <= hwdata[`PLD_MODE_MSB:`PLD_MODE_LSB];
                    main_bypass_reg <= hwdata[`PLD_BIT_MAIN_BYPASS];
                end
                `PLD_IDX_REF_DIV_HIGH: ref_div_reg[13:8] <= hwdata[5:0];
                `PLD_IDX_REF_DIV_LOW: ref_div_reg[7:0] <= hwdata[7:0];
                `PLD_IDX_DIST_SELECT: dist_select_reg <= hwdata[`PLD_BIT_DIST_SELECT];
                `PLD_IDX_SWALLOW_COUNT: swallow_reg <= hwdata[5:0];
                `PLD_IDX_MAIN_DIV_HIGH: main_div_reg[12:8] <= hwdata[4:0];
                `PLD_IDX_MAIN_DIV_LOW: main_div_reg[7:0] <= hwdata[7:0];
                // status and tallies are read-only; writes land here
                default: shared_reset_reg <= shared_reset_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; the edge detector reads stages two and three

    // stage three is kept only to spot the rising edge
    reg [2:0] ref_sync_reg;
    reg [2:0] osc_sync_reg;
    wire ref_tick;
    wire osc_tick;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_sync_reg <= 3'h0;
            osc_sync_reg <= 3'h0;
        end else begin
            ref_sync_reg <= {ref_sync_reg[1:0], reference_clock_input};
            osc_sync_reg <= {osc_sync_reg[1:0], oscillator_feedback_input};
        end
    end

    // inputs must stay below a quarter of hclk to be counted edge for edge
    assign ref_tick = ref_sync_reg[1] & ~ref_sync_reg[2];
    assign osc_tick = osc_sync_reg[1] & ~osc_sync_reg[2];

    ////////////////////////////////////////////////////////////////////////////////
    // distribution source: a plain mux, no retiming, so the clock keeps its jitter

    // a select change while both clocks run may leave a runt pulse
    assign distribution_clock = dist_select_reg ? auxiliary_clock_input : oscillator_feedback_input;

    ////////////////////////////////////////////////////////////////////////////////
    // reference divider

    // only the shared bit clears this counter
    pld_divider #(
        .W(`PLD_REF_W)
    ) u_ref_div (
        .clk(hclk),
        .rst_n(hresetn),
        .clr(shared_reset_reg),
        .tick(ref_tick),
        .div_val(ref_div_reg),
        .pulse(pfd_reference_pulse)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // feedback divider: prescaler, swallow and main counters

    wire ab_clr;
    wire dual_mode;
    wire ps_mod_hi;
    wire ps_pulse;
    // counts after mode and bypass are applied
    wire [`PLD_SWALLOW_W-1:0] swallow_eff;
    wire [`PLD_MAIN_W-1:0] main_eff;

    reg [`PLD_SWALLOW_W-1:0] swallow_left_reg;
    reg [`PLD_MAIN_W-1:0] main_left_reg;
    reg ab_clr_d_reg;

    // either reset bit holds the prescaler and both counters
    assign ab_clr = shared_reset_reg | ab_reset_reg;
    assign dual_mode = is_dual(ps_mode_reg);
    assign swallow_eff = dual_mode ? swallow_reg : {`PLD_SWALLOW_W{1'b0}};
    // a main count of zero acts as one; status flags it
    assign main_eff = main_bypass_reg ? {{(`PLD_MAIN_W-1){1'b0}}, 1'b1} : main_div_reg;
    // high modulus while swallow count remains, giving p*main + swallow
    assign ps_mod_hi = dual_mode & (swallow_left_reg != {`PLD_SWALLOW_W{1'b0}});

    // the auxiliary pin never reaches the prescaler
    pld_prescaler u_prescaler (
        .clk(hclk),
        .rst_n(hresetn),
        .clr(ab_clr),
        .tick(osc_tick),
        .mode(ps_mode_reg),
        .mod_hi(ps_mod_hi),
        .pulse(ps_pulse)
    );

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // load once after reset so the first frame uses the settings
            ab_clr_d_reg <= 1'b1;
            swallow_left_reg <= {`PLD_SWALLOW_W{1'b0}};
            main_left_reg <= {`PLD_MAIN_W{1'b0}};
            pfd_feedback_pulse <= 1'b0;
        end else begin
            ab_clr_d_reg <= ab_clr;
            pfd_feedback_pulse <= 1'b0;
            if (ab_clr | ab_clr_d_reg) begin
                // load while held and on the cycle of release
                swallow_left_reg <= swallow_eff;
                main_left_reg <= main_eff;
            end else if (ps_pulse) begin
                // one prescaler cycle done; the last main count ends the frame
                if (main_left_reg <= {{(`PLD_MAIN_W-1){1'b0}}, 1'b1}) begin
                    pfd_feedback_pulse <= 1'b1;
                    swallow_left_reg <= swallow_eff;
                    main_left_reg <= main_eff;
                end else begin
                    main_left_reg <= main_left_reg - {{(`PLD_MAIN_W-1){1'b0}}, 1'b1};
                    // a swallow count above the main count is never used up
                    if (swallow_left_reg != {`PLD_SWALLOW_W{1'b0}}) begin
                        swallow_left_reg <= swallow_left_reg - {{(`PLD_SWALLOW_W-1){1'b0}}, 1'b1};
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pulse counters let software check the ratio without a scope

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_pulse_cnt_reg <= 8'h00;
            fb_pulse_cnt_reg <= 8'h00;
        end else begin
            if (pfd_reference_pulse) begin
                ref_pulse_cnt_reg <= ref_pulse_cnt_reg + 8'h01;
            end

            if (pfd_feedback_pulse) begin
                fb_pulse_cnt_reg <= fb_pulse_cnt_reg + 8'h01;
            end
        end
    end
endmodule

// [test/pld_clk_src.sv]
// reference, oscillator and auxiliary clock sources around the dividers
`timescale 1ns/1ps
module pld_clk_src #(
    parameter REF_HALF = 113,
    parameter OSC_HALF = 131,
    parameter AUX_HALF = 97
) (
    input wire run,
    input wire slow,
    output reg ref_clk,
    output reg osc_clk,
    output reg aux_clk,
    output integer ref_edges,
    output integer osc_edges
);
    // halves stay above two bus cycles so the synchronisers see every edge
    initial begin
        ref_clk = 1'b0;
        ref_edges = 0;
        forever begin
            wait (run === 1'b1);
            #(slow ? 2 * REF_HALF : REF_HALF) ref_clk = 1'b1;
            ref_edges = ref_edges + 1;
            #(slow ? 2 * REF_HALF : REF_HALF) ref_clk = 1'b0;
        end
    end
    initial begin
        osc_clk = 1'b0;
        osc_edges = 0;
        forever begin
            wait (run === 1'b1);
            #(slow ? 2 * OSC_HALF : OSC_HALF) osc_clk = 1'b1;
            osc_edges = osc_edges + 1;
            #(slow ? 2 * OSC_HALF : OSC_HALF) osc_clk = 1'b0;
        end
    end
    // auxiliary input only reaches the distribution mux, so it runs free
    initial aux_clk = 1'b0;
    always #AUX_HALF aux_clk = ~aux_clk;
endmodule

// [test/pld_top_properties.sv]
// concurrent checks on the divider block's bus and pulse ports
`timescale 1ns/1ps
`include "pld_consts.vh"
module pld_props (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    input wire auxiliary_clock_input,
    input wire oscillator_feedback_input,
    input wire distribution_clock,
    input wire pfd_reference_pulse,
    input wire pfd_feedback_pulse
);
    wire taken = hsel & hready & htrans[1];
    wire mapped = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
    reg wr_reg;
    reg [7:0] idx_reg;
    reg sel_reg;
    reg shr_reg;
    reg abr_reg;
    ////////////////////////////////////////////////////////////////
    // shadow of the control bits, tracked from bus writes
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_reg <= 1'b0;
            idx_reg <= 8'h00;
            sel_reg <= 1'b1;
            shr_reg <= 1'b0;
            abr_reg <= 1'b0;
        end else if (hready) begin
            wr_reg <= taken & hwrite & mapped;
            idx_reg <= haddr[9:2];
            if (wr_reg && idx_reg == `PLD_IDX_DIST_SELECT) sel_reg <= hwdata[0];
            if (wr_reg && idx_reg == `PLD_IDX_COUNTER_RESET) begin
                shr_reg <= hwdata[0];
                abr_reg <= hwdata[1];
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence rd_taken;
        taken && !hwrite;
    endsequence
    sequence rd_answer;
        !hreadyout ##1 hreadyout;
    endsequence
    read_one_wait_a: assert property (rd_taken |=> rd_answer)
        else $error("read wait state wrong");
    write_no_wait_a: assert property (taken && hwrite |=> hreadyout)
        else $error("write stalled");
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    bad_read_zero_a: assert property (taken && !hwrite && !mapped |=> ##1 hreadyout && hrdata == 32'h0)
        else $error("unmapped read not zero");
    dist_mux_a: assert property (distribution_clock == (sel_reg ? auxiliary_clock_input : oscillator_feedback_input))
        else $error("distribution source wrong");
    ref_single_a: assert property (pfd_reference_pulse |=> !pfd_reference_pulse)
        else $error("reference pulse too long");
    fb_single_a: assert property (pfd_feedback_pulse |=> !pfd_feedback_pulse)
        else $error("feedback pulse too long");
    shared_hold_a: assert property (shr_reg [*4] |-> !pfd_reference_pulse && !pfd_feedback_pulse)
        else $error("pulse during shared reset");
    ab_hold_a: assert property (abr_reg [*4] |-> !pfd_feedback_pulse)
        else $error("feedback pulse during counter reset");
    reset_state_a: assert property ($rose(hresetn) |-> hreadyout && hrdata == 32'h0 && !pfd_feedback_pulse)
        else $error("state after reset wrong");
endmodule
bind pld_top pld_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .auxiliary_clock_input(auxiliary_clock_input), .oscillator_feedback_input(oscillator_feedback_input),
    .distribution_clock(distribution_clock), .pfd_reference_pulse(pfd_reference_pulse),
    .pfd_feedback_pulse(pfd_feedback_pulse));

// [test/pld_top_tb.sv]
// self-checking bench for the pll divider block
`timescale 1ns/1ps
`include "pld_consts.vh"
module pld_top_tb;
    reg hclk, hresetn, hsel, hwrite, run, slow, byp;
    reg [31:0] haddr, hwdata, rv;
    reg [1:0] htrans;
    reg [2:0] hsize, mode;
    reg [7:0] r_hi, r_lo, main_v, sw_v, ps_v, cr, cf;
    wire hreadyout, hresp, ref_clk, osc_clk, aux_clk;
    wire [31:0] hrdata;
    integer ref_edges, osc_edges, num_errors, n_compared, i, p, nref, nfb, dref, dfb, eref, eosc;
    reg [7:0] rst_idx [0:6] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h45, 8'h05, 8'h06};
    always #25 hclk = ~hclk;
    pld_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .reference_clock_input(ref_clk), .auxiliary_clock_input(aux_clk), .oscillator_feedback_input(osc_clk),
        .distribution_clock(), .pfd_reference_pulse(), .pfd_feedback_pulse());
    pld_clk_src src (.run(run), .slow(slow), .ref_clk(ref_clk), .osc_clk(osc_clk), .aux_clk(aux_clk),
        .ref_edges(ref_edges), .osc_edges(osc_edges));
    ////////////////////////////////////////////////////////////////
    task close_out;
        begin
            $display("compared %0d, mismatches %0d", n_compared, num_errors);
            if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    task chk_val(input string what, input [31:0] exp, input [31:0] got);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("[ERR] %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task xfer(input [31:0] a, input w, input [31:0] d);
        begin
            hsel <= 1'b1;
            haddr <= a;
            htrans <= 2'b10;
            hwrite <= w;
            do @(posedge hclk); while (hreadyout !== 1'b1);
            htrans <= 2'b00;
            hwdata <= d;
            do @(posedge hclk); while (hreadyout !== 1'b1);
            rv = hrdata;
        end
    endtask
    task wr(input [7:0] idx, input [7:0] d);
        xfer({22'h0, idx, 2'h0}, 1'b1, {24'h0, d});
    endtask
    task rd(input [7:0] idx, input string what, input [31:0] exp, input [31:0] mask);
        begin
            xfer({22'h0, idx, 2'h0}, 1'b0, 32'h0);
            chk_val(what, exp, rv & mask);
        end
    endtask
    // runs both sources for at least the given edge counts, then counts pulses
    task measure(input integer nr, input integer no);
        begin
            xfer({22'h0, `PLD_IDX_REF_PULSE_COUNT, 2'h0}, 1'b0, 32'h0);
            cr = rv[7:0];
            xfer({22'h0, `PLD_IDX_FB_PULSE_COUNT, 2'h0}, 1'b0, 32'h0);
            cf = rv[7:0];
            eref = ref_edges;
            eosc = osc_edges;
            run <= 1'b1;
            while (ref_edges - eref < nr || osc_edges - eosc < no) @(posedge hclk);
            run <= 1'b0;
            repeat (24) @(posedge hclk);
            eref = ref_edges - eref;
            eosc = osc_edges - eosc;
            xfer({22'h0, `PLD_IDX_REF_PULSE_COUNT, 2'h0}, 1'b0, 32'h0);
            dref = (rv[7:0] - cr) & 8'hff;
            xfer({22'h0, `PLD_IDX_FB_PULSE_COUNT, 2'h0}, 1'b0, 32'h0);
            dfb = (rv[7:0] - cf) & 8'hff;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (90000) @(posedge hclk);
        num_errors = num_errors + 1;
        close_out;
    end
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        run = 1'b0;
        slow = 1'b0;
        num_errors = 0;
        n_compared = 0;
        void'($urandom(96441));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (i = 0; i < 7; i = i + 1) rd(rst_idx[i], "reset value", {31'h0, i == 4}, 32'hff);
        xfer(32'h400, 1'b1, 32'h5a);
        xfer(32'h400, 1'b0, 32'h0);
        chk_val("unmapped read", 32'h0, rv);
        wr(`PLD_IDX_DIST_SELECT, 8'h00);
        rd(`PLD_IDX_DIST_SELECT, "dist select", 32'h0, 32'h1);
        for (i = 0; i < 8; i = i + 1) begin
            mode = i;
            p = (i == 0) ? 1 : (i == 7) ? 3 : (i == 1) ? 2 : 1 << (i - 1);
            main_v = 3 + $urandom % 4;
            sw_v = $urandom % (main_v + 1);
            byp = (i < 2 || i == 7) ? $urandom % 2 : 1'b0;
            slow = $urandom % 2;
            r_hi = (i == 1) ? 8'hc1 : 8'h00;
            r_lo = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : 1 + $urandom % 12;
            nref = {r_hi[5:0], r_lo};
            if (nref == 0) nref = 1;
            nfb = (i < 2 || i == 7) ? p * (byp ? 1 : main_v) : p * main_v + sw_v;
            ps_v = {1'b0, byp, 1'b0, mode, 2'b00};
            wr(`PLD_IDX_REF_DIV_HIGH, r_hi);
            wr(`PLD_IDX_REF_DIV_LOW, r_lo);
            wr(`PLD_IDX_SWALLOW_COUNT, sw_v);
            wr(`PLD_IDX_MAIN_DIV_HIGH, 8'h00);
            wr(`PLD_IDX_MAIN_DIV_LOW, main_v);
            rd(`PLD_IDX_REF_DIV_HIGH, "ref divide high", {26'h0, r_hi[5:0]}, 32'h3f);
            wr(`PLD_IDX_PRESCALER_CTRL, ps_v);
            wr(`PLD_IDX_COUNTER_RESET, 8'h01);
            wr(`PLD_IDX_COUNTER_RESET, 8'h00);
            measure(2 * nref + 3, 2 * nfb + 3);
            rd(`PLD_IDX_PRESCALER_CTRL, "prescaler ctrl", ps_v, 32'hff);
            chk_val("ref pulses", (eref / nref) & 255, dref);
            chk_val("fb pulses", (eosc / nfb) & 255, dfb);
        end
        wr(`PLD_IDX_COUNTER_RESET, 8'h01);
        wr(`PLD_IDX_COUNTER_RESET, 8'h02);
        measure(2 * nref + 3, 20);
        chk_val("ref pulses in counter reset", (eref / nref) & 255, dref);
        chk_val("fb pulses in counter reset", 32'h0, dfb);
        wr(`PLD_IDX_COUNTER_RESET, 8'h01);
        measure(20, 20);
        chk_val("ref pulses in shared reset", 32'h0, dref);
        chk_val("fb pulses in shared reset", 32'h0, dfb);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(`PLD_IDX_DIST_SELECT, "dist select after reset", 32'h1, 32'h1);
        rd(`PLD_IDX_MAIN_DIV_LOW, "main after reset", 32'h0, 32'hff);
        rd(`PLD_IDX_STATUS, "status after reset", 32'ha, 32'hf);
        close_out;
    end
endmodule
